// ==== hxl_host_model.sv ====
// Host model: sends hex records over serial and collects device bytes.
// Assumes 8N1 framing at CPB clocks per bit on ref_clk.
`timescale 1ns/100ps
module hxl_host_model #(
    parameter int CPB = 16
) (
    input  wire logic ref_clk,
    input  wire logic dev_tx,
    output logic      host_tx
);
    logic [7:0] rxq[$], rx_b;
    int         gap = 1;
    initial host_tx = 1'b1;
    // Receiver sampling mid-bit, drops bytes with a low stop bit
    always begin
        @(negedge dev_tx);
        repeat (CPB / 2) @(posedge ref_clk);
        if (!dev_tx) begin
            for (int i = 0; i < 8; i++) begin
                repeat (CPB) @(posedge ref_clk);
                rx_b[i] = dev_tx;
            end
            repeat (CPB) @(posedge ref_clk);
            if (dev_tx)
                rxq.push_back(rx_b);
        end
    end
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge ref_clk);
            host_tx <= f[i];
            repeat (CPB - 1) @(negedge ref_clk);
        end
        repeat (gap * CPB) @(negedge ref_clk);
    endtask : send_byte
    task automatic send_hex(input logic [7:0] v);
        send_byte(v[7:4] < 4'hA ? 8'h30 + v[7:4] : 8'h37 + v[7:4]);
        send_byte(v[3:0] < 4'hA ? 8'h30 + v[3:0] : 8'h37 + v[3:0]);
    endtask : send_hex
    // Record sent as generated; err offsets the checksum on purpose
    task automatic send_record(input logic [7:0] cnt, input logic [15:0] addr,
        input logic [7:0] typ, input logic [7:0] d0, input logic [7:0] err);
        logic [7:0] sum;
        sum = cnt + addr[15:8] + addr[7:0] + typ;
        send_byte(8'h3A);
        send_hex(cnt);
        send_hex(addr[15:8]);
        send_hex(addr[7:0]);
        send_hex(typ);
        for (int i = 0; i < cnt; i++) begin
            send_hex(d0 + 8'(i));
            sum = sum + d0 + 8'(i);
        end
        send_hex(8'h00 - sum + err);
    endtask : send_record
endmodule : hxl_host_model

// ==== hxl_loader.sv ====
// Serial hex record loader: erases flash, answers interrogation, programs
// hex records into program flash and launches code on a run command.
// Assumes a flash controller on ref_clk that pulses flash_done per request.
//
// How it works
// - Only program flash is ever written; no data flash write exists.
// - On activation erase program then data flash, then send identity.
// - After identity, wait for hex records and program each good data one.
// - A colon character starts a new record.
// - Count and address come from leading fields; checksum ends the record.
// - Each record ends with one answer byte, 0x06 good or 0x07 bad.
// - After a bad record, discard input until the next colon or interrogation byte.
// - Semicolon plus four-character address starts code at that address.
// - Without a run command, user code never starts from the loader.
// - Record is mark, count, address, type, up to 16 data, checksum.
// - Type 00 is data, 01 is end of file.
// - Sum of all record bytes and checksum must be zero modulo 256.
// - Serial port uses 8 data bits, no parity.
// - Bit time is fixed in clocks so baud scales with the clock.
// - Interrogation byte 0x21 returns the 11-byte identity at once.
`timescale 1ns/100ps
`include "hxl_loader_regs.svh"
module hxl_loader #(
    parameter int          CLKS_PER_BIT = `HXL_CLKS_PER_BIT,
    // Identity string, 8-byte name then 3-byte version; value arbitrary
    parameter logic [87:0] ID_STRING    = 88'h4C4F414445523031763130
) (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              download_strap_pin_n,
    input  wire logic              uart_rx,
    output logic                   uart_tx,
    output logic                   loader_active,
    output logic                   flash_req,
    output hxl_pkg::hxl_flash_op_e flash_op,
    output logic [15:0]            flash_addr,
    output logic [7:0]             flash_wdata,
    input  wire logic              flash_done,
    output logic                   run_start,
    output logic [15:0]            run_addr
);
    import hxl_pkg::*;

    hxl_ser_if ser ();

    hxl_uart #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_uart (
        .ref_clk (ref_clk),
        .reset   (reset),
        .rx_pin  (uart_rx),
        .tx_pin  (uart_tx),
        .ser     (ser)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    hxl_state_e    state_r, state_nxt;
    hxl_flash_op_e op_r, op_nxt;
    logic          strap_s1_r, strap_s2_r;
    logic [1:0]    wait_r, wait_nxt;
    logic [3:0]    id_idx_r, id_idx_nxt;
    logic          half_r, half_nxt;
    logic [3:0]    nib_r, nib_nxt;
    logic [4:0]    bidx_r, bidx_nxt;
    logic [7:0]    cnt_r, cnt_nxt;
    logic [15:0]   addr_r, addr_nxt;
    logic [7:0]    type_r, type_nxt;
    logic [7:0]    sum_r, sum_nxt;
    logic [7:0]    resp_r, resp_nxt;
    logic [4:0]    wr_idx_r, wr_idx_nxt;
    logic [15:0]   fa_r, fa_nxt;
    logic [7:0]    fd_r, fd_nxt;
    logic [15:0]   run_addr_r, run_addr_nxt;
    logic          run_start_r, run_start_nxt;
    logic [7:0]    buf_r [16];

    // ----------------------------------------
    // Character decoding
    // ----------------------------------------
    wire [7:0] ch      = ser.rx_data;
    wire       is_dig  = ch >= 8'h30 && ch <= 8'h39;
    wire       is_up   = ch >= 8'h41 && ch <= 8'h46;
    wire       is_low  = ch >= 8'h61 && ch <= 8'h66;
    wire       hex_ok  = is_dig || is_up || is_low;
    wire [7:0] hex_sub = is_dig ? 8'h30 : (is_up ? 8'h37 : 8'h57);
    wire [7:0] hex_w   = ch - hex_sub;
    wire [3:0] hex_val = hex_w[3:0];
    wire [7:0] byte_in = {nib_r, hex_val};
    wire [4:0] dpos    = bidx_r - `HXL_POS_DATA;
    wire       is_data = bidx_r >= `HXL_POS_DATA && {3'h0, dpos} < cnt_r;
    wire       is_ck   = {3'h0, bidx_r} == cnt_r + {3'h0, `HXL_POS_DATA};
    wire [7:0] sum_all = sum_r + byte_in;
    wire       typ_ok  = type_r == `HXL_TYPE_DATA || type_r == `HXL_TYPE_EOF;
    wire       byte_ev = state_r == HXL_ST_HEX && ser.rx_valid && hex_ok && half_r;
    wire       buf_we  = byte_ev && is_data;
    wire [6:0] id_sh   = 7'(({3'h0, `HXL_ID_LEN} - 7'h01 - {3'h0, id_idx_r}) * 8);
    wire [87:0] id_w   = ID_STRING >> id_sh;

    assign ser.tx_valid  = state_r == HXL_ST_ID || state_r == HXL_ST_RESP;
    assign ser.tx_data   = state_r == HXL_ST_ID ? id_w[7:0] : resp_r;
    assign flash_req     = state_r == HXL_ST_ERASE_P || state_r == HXL_ST_ERASE_D
                           || state_r == HXL_ST_PROG;
    assign flash_op      = op_r;
    assign flash_addr    = fa_r;
    assign flash_wdata   = fd_r;
    assign run_start     = run_start_r;
    assign run_addr      = run_addr_r;
    assign loader_active = state_r != HXL_ST_OFF && state_r != HXL_ST_STRAP
                           && state_r != HXL_ST_RAN;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_nxt     = state_r;
        op_nxt        = op_r;
        wait_nxt      = wait_r;
        id_idx_nxt    = id_idx_r;
        half_nxt      = half_r;
        nib_nxt       = nib_r;
        bidx_nxt      = bidx_r;
        cnt_nxt       = cnt_r;
        addr_nxt      = addr_r;
        type_nxt      = type_r;
        sum_nxt       = sum_r;
        resp_nxt      = resp_r;
        wr_idx_nxt    = wr_idx_r;
        fa_nxt        = fa_r;
        fd_nxt        = fd_r;
        run_addr_nxt  = run_addr_r;
        run_start_nxt = 1'b0;
        unique case (state_r)
            HXL_ST_STRAP: begin
                wait_nxt = wait_r + 2'h1;
                if (wait_r == `HXL_STRAP_SETTLE) begin
                    state_nxt = strap_s2_r ? HXL_ST_OFF : HXL_ST_ERASE_P;
                    op_nxt    = HXL_FL_ERASE_PROG;
                end
            end
            HXL_ST_ERASE_P: if (flash_done) begin
                state_nxt = HXL_ST_ERASE_D;
                op_nxt    = HXL_FL_ERASE_DATA;
            end
            HXL_ST_ERASE_D: if (flash_done) begin
                state_nxt  = HXL_ST_ID;
                id_idx_nxt = 4'h0;
            end
            HXL_ST_ID: if (ser.tx_ready) begin
                id_idx_nxt = id_idx_r + 4'h1;
                if (id_idx_r == `HXL_ID_LEN - 4'h1) state_nxt = HXL_ST_WAIT;
            end
            HXL_ST_WAIT, HXL_ST_SKIP: if (ser.rx_valid) begin
                if (ch == `HXL_CHR_MARK) begin
                    state_nxt = HXL_ST_HEX;
                    half_nxt  = 1'b0;
                    bidx_nxt  = 5'h00;
                    sum_nxt   = 8'h00;
                end else if (ch == `HXL_CHR_QUERY) begin
                    state_nxt  = HXL_ST_ID;
                    id_idx_nxt = 4'h0;
                end else if (ch == `HXL_CHR_RUN && state_r == HXL_ST_WAIT) begin
                    state_nxt = HXL_ST_RUNA;
                    bidx_nxt  = 5'h00;
                end
            end
            HXL_ST_HEX: if (ser.rx_valid) begin
                if (!hex_ok) begin
                    state_nxt = HXL_ST_RESP;
                    resp_nxt  = `HXL_CHR_NACK;
                end else if (!half_r) begin
                    nib_nxt  = hex_val;
                    half_nxt = 1'b1;
                end else begin
                    half_nxt = 1'b0;
                    bidx_nxt = bidx_r + 5'h01;
                    sum_nxt  = sum_all;
                    if (bidx_r == `HXL_POS_COUNT) begin
                        cnt_nxt = byte_in;
                        if (byte_in > `HXL_MAX_DATA) begin
                            state_nxt = HXL_ST_RESP;
                            resp_nxt  = `HXL_CHR_NACK;
                        end
                    end else if (bidx_r == `HXL_POS_ADDR_HI) begin
                        addr_nxt[15:8] = byte_in;
                    end else if (bidx_r == `HXL_POS_ADDR_LO) begin
                        addr_nxt[7:0] = byte_in;
                    end else if (bidx_r == `HXL_POS_TYPE) begin
                        type_nxt = byte_in;
                    end else if (is_ck) begin
                        state_nxt = HXL_ST_RESP;
                        if (sum_all != 8'h00 || !typ_ok) begin
                            resp_nxt = `HXL_CHR_NACK;
                        end else if (type_r == `HXL_TYPE_DATA && cnt_r != 8'h00) begin
                            state_nxt  = HXL_ST_PROG;
                            op_nxt     = HXL_FL_WRITE_PROG;
                            wr_idx_nxt = 5'h00;
                            fa_nxt     = addr_r;
                            fd_nxt     = buf_r[0];
                        end else begin
                            resp_nxt = `HXL_CHR_ACK;
                        end
                    end
                end
            end
            HXL_ST_PROG: if (flash_done) begin
                if ({3'h0, wr_idx_r} == cnt_r - 8'h01) begin
                    state_nxt = HXL_ST_RESP;
                    resp_nxt  = `HXL_CHR_ACK;
                end else begin
                    wr_idx_nxt = wr_idx_r + 5'h01;
                    fa_nxt     = fa_r + 16'h0001;
                    fd_nxt     = buf_r[4'(wr_idx_r + 5'h01)];
                end
            end
            HXL_ST_RESP: if (ser.tx_ready) begin
                state_nxt = resp_r == `HXL_CHR_ACK ? HXL_ST_WAIT : HXL_ST_SKIP;
            end
            HXL_ST_RUNA: if (ser.rx_valid) begin
                if (!hex_ok) begin
                    state_nxt = HXL_ST_WAIT;
                end else begin
                    run_addr_nxt = {run_addr_r[11:0], hex_val};
                    bidx_nxt     = bidx_r + 5'h01;
                    if (bidx_r == `HXL_RUN_CHARS) begin
                        state_nxt     = HXL_ST_RAN;
                        run_start_nxt = 1'b1;
                    end
                end
            end
            HXL_ST_RAN, HXL_ST_OFF: state_nxt = state_r;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_r     <= HXL_ST_STRAP;
            op_r        <= HXL_FL_ERASE_PROG;
            strap_s1_r  <= 1'b1;
            strap_s2_r  <= 1'b1;
            wait_r      <= 2'h0;
            id_idx_r    <= 4'h0;
            half_r      <= 1'b0;
            nib_r       <= 4'h0;
            bidx_r      <= 5'h00;
            cnt_r       <= 8'h00;
            addr_r      <= 16'h0000;
            type_r      <= 8'h00;
            sum_r       <= 8'h00;
            resp_r      <= 8'h00;
            wr_idx_r    <= 5'h00;
            fa_r        <= 16'h0000;
            fd_r        <= 8'h00;
            run_addr_r  <= 16'h0000;
            run_start_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            op_r        <= op_nxt;
            strap_s1_r  <= download_strap_pin_n;
            strap_s2_r  <= strap_s1_r;
            wait_r      <= wait_nxt;
            id_idx_r    <= id_idx_nxt;
            half_r      <= half_nxt;
            nib_r       <= nib_nxt;
            bidx_r      <= bidx_nxt;
            cnt_r       <= cnt_nxt;
            addr_r      <= addr_nxt;
            type_r      <= type_nxt;
            sum_r       <= sum_nxt;
            resp_r      <= resp_nxt;
            wr_idx_r    <= wr_idx_nxt;
            fa_r        <= fa_nxt;
            fd_r        <= fd_nxt;
            run_addr_r  <= run_addr_nxt;
            run_start_r <= run_start_nxt;
        end
    end

    // Record data buffer
    always_ff @(posedge ref_clk) begin
        if (buf_we) buf_r[dpos[3:0]] <= byte_in;
    end
endmodule : hxl_loader

// ==== hxl_loader_regs.svh ====
// Constants for the serial hex record loader.
// Assumes inclusion by bare name from the loader, its serial port and its checker.
`ifndef HXL_LOADER_REGS_SVH
`define HXL_LOADER_REGS_SVH

// ----------------------------------------
// Serial timing
// ----------------------------------------
`define HXL_REF_CLK_HZ      11059200
`define HXL_REF_BAUD        9600
`define HXL_CLKS_PER_BIT    (`HXL_REF_CLK_HZ / `HXL_REF_BAUD)
`define HXL_STRAP_SETTLE    2'h3

// ----------------------------------------
// Characters and answers
// ----------------------------------------
`define HXL_CHR_MARK        8'h3A
`define HXL_CHR_RUN         8'h3B
`define HXL_CHR_QUERY       8'h21
`define HXL_CHR_ACK         8'h06
`define HXL_CHR_NACK        8'h07

// ----------------------------------------
// Record layout
// ----------------------------------------
`define HXL_TYPE_DATA       8'h00
`define HXL_TYPE_EOF        8'h01
`define HXL_MAX_DATA        8'h10
`define HXL_POS_COUNT       5'h00
`define HXL_POS_ADDR_HI     5'h01
`define HXL_POS_ADDR_LO     5'h02
`define HXL_POS_TYPE        5'h03
`define HXL_POS_DATA        5'h04
`define HXL_ID_LEN          4'hB
`define HXL_RUN_CHARS       5'h03

`endif

// ==== hxl_loader_sva.sv ====
// Assertion checker for the loader top module ports.
// Assumes one clock domain on ref_clk and a bind from the testbench.
`timescale 1ns/100ps
`include "hxl_loader_regs.svh"
module hxl_loader_sva #(
    parameter int CLKS_PER_BIT = `HXL_CLKS_PER_BIT
) (
    input wire logic                   ref_clk,
    input wire logic                   reset,
    input wire logic                   download_strap_pin_n,
    input wire logic                   uart_rx,
    input wire logic                   uart_tx,
    input wire logic                   loader_active,
    input wire logic                   flash_req,
    input wire hxl_pkg::hxl_flash_op_e flash_op,
    input wire logic [15:0]            flash_addr,
    input wire logic [7:0]             flash_wdata,
    input wire logic                   flash_done,
    input wire logic                   run_start,
    input wire logic [15:0]            run_addr
);
    import hxl_pkg::*;
    logic [15:0] low_r;
    wire         wr_done = flash_done && flash_req && flash_op == HXL_FL_WRITE_PROG;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Length of the current low run on the serial output
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset)
            low_r <= 16'h0000;
        else
            low_r <= uart_tx ? 16'h0000 : low_r + 16'h0001;
    end
    chk_erase_first: assert property ($rose(loader_active) |->
        flash_req && flash_op == HXL_FL_ERASE_PROG) else $error("erase did not start first");
    chk_erase_data: assert property (flash_done && flash_req &&
        flash_op == HXL_FL_ERASE_PROG |=> flash_req && flash_op == HXL_FL_ERASE_DATA)
        else $error("data erase did not follow");
    chk_id_after: assert property (flash_done && flash_req &&
        flash_op == HXL_FL_ERASE_DATA |=> !flash_req ##[0:3] !uart_tx)
        else $error("identity did not follow erase");
    chk_no_dwrite: assert property (flash_req && flash_op == HXL_FL_ERASE_DATA |->
        $past(flash_op) != HXL_FL_WRITE_PROG) else $error("data flash touched after write");
    chk_req_holds: assert property (flash_req && !flash_done |=> flash_req &&
        $stable(flash_op) && $stable(flash_addr) && $stable(flash_wdata))
        else $error("flash request changed before done");
    chk_addr_step: assert property (wr_done ##1 (flash_req &&
        flash_op == HXL_FL_WRITE_PROG) |-> flash_addr == $past(flash_addr) + 16'h0001)
        else $error("write address not consecutive");
    chk_run_pulse: assert property (run_start |=>
        (!run_start && !loader_active && $stable(run_addr)) [*4]) else $error("run pulse bad");
    chk_no_run: assert property (!loader_active && !run_start |=> !run_start)
        else $error("run without loader");
    chk_tx_idle: assert property (!loader_active |-> uart_tx)
        else $error("tx busy while inactive");
    chk_bit_time: assert property ($rose(uart_tx) |->
        (32'(low_r) % CLKS_PER_BIT) == 0) else $error("low run not whole bit times");
endmodule : hxl_loader_sva

// ==== hxl_pkg.sv ====
// Types shared by the loader core and its serial port.
// Assumes nothing of its surroundings.
package hxl_pkg;

    typedef enum logic [1:0] {
        HXL_FL_ERASE_PROG,
        HXL_FL_ERASE_DATA,
        HXL_FL_WRITE_PROG
    } hxl_flash_op_e;

    typedef enum logic [3:0] {
        HXL_ST_STRAP,
        HXL_ST_ERASE_P,
        HXL_ST_ERASE_D,
        HXL_ST_ID,
        HXL_ST_WAIT,
        HXL_ST_SKIP,
        HXL_ST_HEX,
        HXL_ST_PROG,
        HXL_ST_RESP,
        HXL_ST_RUNA,
        HXL_ST_RAN,
        HXL_ST_OFF
    } hxl_state_e;

endpackage : hxl_pkg

// ==== hxl_ser_if.sv ====
// Byte stream between the loader core and its serial port.
// Assumes both ends run on ref_clk.
`timescale 1ns/100ps
interface hxl_ser_if;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       tx_valid;
    logic       tx_ready;
    logic [7:0] tx_data;

    modport uart (output rx_valid, output rx_data, input tx_valid,
                  output tx_ready, input tx_data);
    modport core (input rx_valid, input rx_data, output tx_valid,
                  input tx_ready, output tx_data);
endinterface : hxl_ser_if

// ==== hxl_uart.sv ====
// Serial port of the loader: 8 data bits, no parity, one stop bit.
// Assumes rx_pin is asynchronous to ref_clk.
`timescale 1ns/100ps
`include "hxl_loader_regs.svh"
module hxl_uart #(
    parameter int CLKS_PER_BIT = `HXL_CLKS_PER_BIT
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic rx_pin,
    output logic      tx_pin,
    hxl_ser_if.uart   ser
);
    import hxl_pkg::*;

    logic        rx_s1_r, rx_s2_r, rx_busy_r, rx_valid_r;
    logic [15:0] rx_cnt_r;
    logic [3:0]  rx_bit_r;
    logic [7:0]  rx_sh_r;
    logic        tx_busy_r, tx_line_r;
    logic [15:0] tx_cnt_r;
    logic [3:0]  tx_bit_r;
    logic [9:0]  tx_sh_r;
    wire         rx_tick = rx_cnt_r == 16'h0000;
    wire         tx_tick = tx_cnt_r == 16'h0000;

    // ----------------------------------------
    // Receiver, sampled mid-bit
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_s1_r    <= 1'b1;
            rx_s2_r    <= 1'b1;
            rx_busy_r  <= 1'b0;
            rx_valid_r <= 1'b0;
            rx_cnt_r   <= 16'h0000;
            rx_bit_r   <= 4'h0;
            rx_sh_r    <= 8'h00;
        end else begin
            rx_s1_r    <= rx_pin;
            rx_s2_r    <= rx_s1_r;
            rx_valid_r <= 1'b0;
            if (!rx_busy_r) begin
                if (!rx_s2_r) begin
                    rx_busy_r <= 1'b1;
                    rx_cnt_r  <= 16'(CLKS_PER_BIT / 2);
                    rx_bit_r  <= 4'h0;
                end
            end else if (!rx_tick) begin
                rx_cnt_r <= rx_cnt_r - 16'h0001;
            end else begin
                rx_cnt_r <= 16'(CLKS_PER_BIT - 1);
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0 && rx_s2_r) begin
                    rx_busy_r <= 1'b0;
                end else if (rx_bit_r == 4'h9) begin
                    rx_busy_r  <= 1'b0;
                    rx_valid_r <= rx_s2_r;
                end else if (rx_bit_r != 4'h0) begin
                    rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
                end
            end
        end
    end

    assign ser.rx_valid = rx_valid_r;
    assign ser.rx_data  = rx_sh_r;

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    assign ser.tx_ready = !tx_busy_r;
    assign tx_pin       = tx_line_r;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_busy_r <= 1'b0;
            tx_line_r <= 1'b1;
            tx_cnt_r  <= 16'h0000;
            tx_bit_r  <= 4'h0;
            tx_sh_r   <= 10'h3FF;
        end else if (!tx_busy_r) begin
            tx_line_r <= 1'b1;
            if (ser.tx_valid) begin
                tx_busy_r <= 1'b1;
                tx_sh_r   <= {1'b1, ser.tx_data, 1'b0};
                tx_bit_r  <= 4'h0;
                tx_cnt_r  <= 16'h0000;
            end
        end else if (!tx_tick) begin
            tx_cnt_r <= tx_cnt_r - 16'h0001;
        end else if (tx_bit_r == 4'hA) begin
            tx_busy_r <= 1'b0;
        end else begin
            tx_line_r <= tx_sh_r[0];
            tx_sh_r   <= {1'b1, tx_sh_r[9:1]};
            tx_bit_r  <= tx_bit_r + 4'h1;
            tx_cnt_r  <= 16'(CLKS_PER_BIT - 1);
        end
    end
endmodule : hxl_uart

// ==== serial_hex_record_loader_test.sv ====
// Testbench for the hex record loader with host and flash responder.
// Assumes a 100 MHz clock and a short bit time for simulation.
`timescale 1ns/100ps
module serial_hex_record_loader_test;
    import hxl_pkg::*;
    localparam int          CPB = 16;
    // Identity value is arbitrary
    localparam logic [87:0] ID  = 88'h5445535449443031763032;
    logic          ref_clk, reset, strap_n, uart_rx, uart_tx, loader_active;
    logic          flash_req, flash_done, run_start;
    hxl_flash_op_e flash_op;
    logic [15:0]   flash_addr, run_addr;
    logic [7:0]    flash_wdata;
    logic [23:0]   wq[$];
    logic [1:0]    eq[$];
    int            mismatches, compares, fl_lat, fl_cnt, runs;
    hxl_loader #(.CLKS_PER_BIT(CPB), .ID_STRING(ID)) dut_u (.ref_clk(ref_clk), .reset(reset),
        .download_strap_pin_n(strap_n), .uart_rx(uart_rx), .uart_tx(uart_tx),
        .loader_active(loader_active), .flash_req(flash_req), .flash_op(flash_op),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_done(flash_done),
        .run_start(run_start), .run_addr(run_addr));
    hxl_host_model #(.CPB(CPB)) host_u (.ref_clk(ref_clk), .dev_tx(uart_tx), .host_tx(uart_rx));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Flash controller: done after fl_lat cycles, logs every completed op
    always @(negedge ref_clk) begin
        flash_done <= flash_req && !flash_done && fl_cnt >= fl_lat;
        fl_cnt     <= (flash_req && !flash_done && fl_cnt < fl_lat) ? fl_cnt + 1 : 0;
    end
    always @(posedge ref_clk) begin
        if (flash_req && flash_done && flash_op == HXL_FL_WRITE_PROG)
            wq.push_back({flash_addr, flash_wdata});
        else if (flash_req && flash_done)
            eq.push_back(flash_op);
        if (run_start)
            runs++;
    end
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic get_byte(output logic [7:0] b);
        int n;
        n = 0;
        while (host_u.rxq.size() == 0 && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
        b = host_u.rxq.size() > 0 ? host_u.rxq.pop_front() : 8'hXX;
    endtask : get_byte
    task automatic do_reset(input logic strap);
        reset   = 1'b1;
        strap_n = strap;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        wq.delete();
        eq.delete();
        host_u.rxq.delete();
    endtask : do_reset
    task automatic expect_id;
        logic [7:0] b;
        for (int k = 0; k < 11; k++) begin
            get_byte(b);
            check("id byte", 24'(b), 24'(ID[87 - 8 * k -: 8]));
        end
    endtask : expect_id
    task automatic t_boot;
        do_reset(1'b0);
        expect_id();
        check("erase ops", 24'(eq.size()), 24'h000002);
        check("erase 1st", 24'(eq[0]), 24'(HXL_FL_ERASE_PROG));
        check("erase 2nd", 24'(eq[1]), 24'(HXL_FL_ERASE_DATA));
        host_u.send_byte(8'h21);
        expect_id();
    endtask : t_boot
    // One record; good data ones expect 0x06 and writes, good EOF ones 0x06 and none, bad ones 0x07 and none
    task automatic t_rec(input logic [7:0] cnt, input logic [15:0] addr, input logic [7:0] typ,
        input logic [7:0] d0, input logic [7:0] err, input logic [7:0] ans);
        logic [7:0] b;
        wq.delete();
        host_u.send_record(cnt, addr, typ, d0, err);
        get_byte(b);
        check("answer", 24'(b), 24'(ans));
        check("writes", 24'(wq.size()), (ans == 8'h06 && typ == 8'h00) ? 24'(cnt) : 24'h0);
        for (int i = 0; i < wq.size(); i++)
            check("write", wq[i], {addr + 16'(i), d0 + 8'(i)});
    endtask : t_rec
    task automatic t_run(input logic expect_run);
        host_u.send_byte(8'h3B);
        host_u.send_byte(8'h66);
        host_u.send_byte(8'h46);
        host_u.send_hex(8'h00);
        repeat (100) @(negedge ref_clk);
        check("runs", 24'(runs), 24'(expect_run));
        check("active", 24'(loader_active), 24'(!expect_run));
        if (expect_run)
            check("run addr", 24'(run_addr), 24'h00FF00);
    endtask : t_run
    task automatic t_halt;
        host_u.send_byte(8'h21);
        repeat (600) @(negedge ref_clk);
        check("no reply", 24'(host_u.rxq.size()), 24'h0);
    endtask : t_halt
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    initial begin
        reset      = 1'b1;
        strap_n    = 1'b0;
        flash_done = 1'b0;
        fl_lat     = 0;
        fl_cnt     = 0;
        runs       = 0;
        t_boot();
        t_rec(8'h01, 16'h0010, 8'h00, 8'h55, 8'h00, 8'h06);
        host_u.gap = 0;
        fl_lat     = 5;
        t_rec(8'h10, 16'hFFF8, 8'h00, 8'hF0, 8'h00, 8'h06);
        t_rec(8'h03, 16'h0100, 8'h00, 8'h11, 8'h01, 8'h07);
        t_run(1'b0);
        t_rec(8'h03, 16'h0100, 8'h00, 8'h11, 8'h00, 8'h06);
        t_rec(8'h11, 16'h0200, 8'h00, 8'h22, 8'h00, 8'h07);
        t_rec(8'h02, 16'h0200, 8'h02, 8'h22, 8'h00, 8'h07);
        host_u.gap = 2;
        t_rec(8'h00, 16'h0000, 8'h01, 8'h00, 8'h00, 8'h06);
        t_run(1'b1);
        t_halt();
        do_reset(1'b1);
        repeat (200) @(negedge ref_clk);
        t_halt();
        check("idle ops", 24'(eq.size()), 24'h0);
        conclude();
    end
    initial begin
        repeat (80000) @(posedge ref_clk);
        mismatches++;
        conclude();
    end
endmodule : serial_hex_record_loader_test
bind hxl_loader hxl_loader_sva #(.CLKS_PER_BIT(CLKS_PER_BIT)) sva_u (.ref_clk(ref_clk),
    .reset(reset), .download_strap_pin_n(download_strap_pin_n), .uart_rx(uart_rx),
    .uart_tx(uart_tx), .loader_active(loader_active), .flash_req(flash_req),
    .flash_op(flash_op), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_done(flash_done), .run_start(run_start), .run_addr(run_addr));
